// ---- sbw_pkg.sv ----
package sbw_pkg;

  // ----------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 3'h0;
  localparam logic [ADDR_W-1:0] DATA_OFS = 3'h1;
  localparam logic [ADDR_W-1:0] BAUD_OFS = 3'h2;
  localparam logic [ADDR_W-1:0] CTRL1_OFS = 3'h3;
  localparam logic [ADDR_W-1:0] CTRL2_OFS = 3'h4;
  localparam logic [ADDR_W-1:0] TXFINE_OFS = 3'h5;
  localparam logic [ADDR_W-1:0] RXFINE_OFS = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_TXEMPTY = 7;
  localparam int ST_TXDONE = 6;
  localparam int ST_RXFULL = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_FRAMERR = 1;
  localparam int C1_RXBIT8 = 7;
  localparam int C1_TXBIT8 = 6;
  localparam int C1_WORDLEN = 4;
  localparam int C1_WAKESEL = 3;
  localparam int C2_RXIE = 5;
  localparam int C2_IDLEIE = 4;
  localparam int C2_TXEN = 3;
  localparam int C2_RXEN = 2;
  localparam int C2_MUTE = 1;
  localparam int C2_BREAK = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FINE_RST = 8'h00;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [3:0] FRAME_8 = 4'hA;
  localparam logic [3:0] FRAME_9 = 4'hB;
  localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SEND = 2'b01, TX_BREAK = 2'b11,
                            TX_MARK = 2'b10} sbw_tx_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
                            RX_STOP = 2'b10} sbw_rx_e;

  function automatic logic [3:0] sbw_prescale(input logic [1:0] sel);
    unique case (sel)
      2'b00: sbw_prescale = 4'h1;
      2'b01: sbw_prescale = 4'h3;
      2'b10: sbw_prescale = 4'h4;
      2'b11: sbw_prescale = 4'hD;
    endcase
  endfunction : sbw_prescale

endpackage : sbw_pkg

// ---- sbw_baud_div.sv ----
`timescale 1ns/10ps
module sbw_baud_div #(
  parameter int CNT_W = 19
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Rate selection
  input wire logic [1:0] prescaleSel,
  input wire logic [2:0] rateSel,
  input wire logic [7:0] fineFactor,
  input wire logic run,
  // Oversample strobe, one cycle wide
  output logic tick
);
  import sbw_pkg::*;

  logic [CNT_W-1:0] periodVal;
  logic [CNT_W-1:0] cnt_reg;
  logic [7:0] fineEff;

  always_comb begin
    // Zero keeps the fine stage out of the path
    fineEff = (fineFactor == 8'h00) ? 8'h01 : fineFactor;
    // Tick period is the bit time over sixteen
    periodVal = CNT_W'((CNT_W'(sbw_prescale(prescaleSel)) * CNT_W'(fineEff)) << rateSel);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg >= periodVal - CNT_W'(1)) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
      tick <= 1'b0;
    end
  end

endmodule : sbw_baud_div

// ---- sbw_serial.sv ----
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module sbw_serial #(
  parameter int DIV_W = 19
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [sbw_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  // Serial lines
  output logic txdOut,
  input wire logic rxdIn,
  // Receive request level
  output logic rxIrqReq
);
  import sbw_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] baud_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] txFine_reg;
  logic [7:0] rxFine_reg;
  logic [7:0] txHold_reg;
  logic [7:0] rxHold_reg;
  logic rxBit8_reg;
  logic txEmpty_reg;
  logic txDone_reg;
  logic rxFull_reg;
  logic idle_reg;
  logic frameErr_reg;
  logic statusSeen_reg;
  logic mute_reg;

  logic wrData;
  logic wrCtrl2;
  logic rdStatus;
  logic rdData;
  logic clearRx;
  logic wordLen9;
  logic wakeAddr;
  logic txEn;
  logic rxEn;

  assign wrData = regWrStb && (regAddr == DATA_OFS);
  assign wrCtrl2 = regWrStb && (regAddr == CTRL2_OFS);
  assign rdStatus = regRdStb && (regAddr == STATUS_OFS);
  assign rdData = regRdStb && (regAddr == DATA_OFS);
  // Status read must precede the data read
  assign clearRx = rdData && statusSeen_reg;
  assign wordLen9 = ctrl1_reg[C1_WORDLEN];
  assign wakeAddr = ctrl1_reg[C1_WAKESEL];
  assign txEn = ctrl2_reg[C2_TXEN];
  assign rxEn = ctrl2_reg[C2_RXEN];

  // Receive and transmit events from the frame logic
  logic rxDone;
  logic rxStopBad;
  logic [7:0] rxWord;
  logic rxWord8;
  logic idleSeen;
  logic wordMsb;
  logic deliver;
  logic txLoad;
  logic txFinish;

  assign wordMsb = wordLen9 ? rxWord8 : rxWord[7];
  // Muted receiver only passes an address word in mark mode
  assign deliver = rxDone && (!mute_reg || (wakeAddr && wordMsb));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      baud_reg <= BAUD_RST;
      ctrl1_reg <= CTRL_RST;
      txFine_reg <= FINE_RST;
      rxFine_reg <= FINE_RST;
      txHold_reg <= 8'h00;
    end else if (regWrStb) begin
      unique case (regAddr)
        BAUD_OFS: baud_reg <= regWrData;
        CTRL1_OFS: ctrl1_reg <= {ctrl1_reg[C1_RXBIT8], regWrData[6:0]};
        TXFINE_OFS: txFine_reg <= regWrData;
        RXFINE_OFS: rxFine_reg <= regWrData;
        DATA_OFS: txHold_reg <= regWrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl2_reg <= CTRL_RST;
      mute_reg <= 1'b0;
    end else if (wrCtrl2) begin
      // A write re-arms mute even across a wake; software avoids it
      ctrl2_reg <= regWrData;
      mute_reg <= regWrData[C2_MUTE];
    end else if ((deliver && mute_reg) || (idleSeen && mute_reg && !wakeAddr)) begin
      mute_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      statusSeen_reg <= 1'b0;
    end else if (rdStatus) begin
      statusSeen_reg <= 1'b1;
    end else if (rdData) begin
      statusSeen_reg <= 1'b0;
    end
  end

  // Set wins over the clear sequence in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxFull_reg <= 1'b0;
      frameErr_reg <= 1'b0;
      rxHold_reg <= 8'h00;
      rxBit8_reg <= 1'b0;
    end else if (deliver) begin
      // Word moves to the buffer even with a bad stop bit
      rxHold_reg <= rxWord;
      rxBit8_reg <= rxWord8;
      rxFull_reg <= 1'b1;
      frameErr_reg <= rxStopBad;
    end else if (clearRx) begin
      rxFull_reg <= 1'b0;
      frameErr_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      idle_reg <= 1'b0;
    end else if (idleSeen && !mute_reg) begin
      idle_reg <= 1'b1;
    end else if (clearRx) begin
      idle_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txEmpty_reg <= 1'b1;
      txDone_reg <= 1'b1;
    end else begin
      if (txLoad) begin
        txEmpty_reg <= 1'b1;
      end else if (wrData) begin
        txEmpty_reg <= 1'b0;
      end
      if (txFinish) begin
        txDone_reg <= 1'b1;
      end else if (wrData) begin
        txDone_reg <= 1'b0;
      end
    end
  end

  // Frame error never feeds the request on its own
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxIrqReq <= 1'b0;
    end else begin
      rxIrqReq <= !mute_reg && ((rxFull_reg && ctrl2_reg[C2_RXIE])
                  || (idle_reg && ctrl2_reg[C2_IDLEIE]));
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (!regRdStb) begin
      regRdData <= 8'h00;
    end else begin
      unique case (regAddr)
        STATUS_OFS: regRdData <= {txEmpty_reg, txDone_reg, rxFull_reg, idle_reg,
                                  2'b00, frameErr_reg, 1'b0};
        DATA_OFS: regRdData <= rxHold_reg;
        BAUD_OFS: regRdData <= baud_reg;
        CTRL1_OFS: regRdData <= {rxBit8_reg, ctrl1_reg[6:0]};
        CTRL2_OFS: regRdData <= {ctrl2_reg[7:2], mute_reg, ctrl2_reg[0]};
        TXFINE_OFS: regRdData <= txFine_reg;
        RXFINE_OFS: regRdData <= rxFine_reg;
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Rate generators
  // ----------------------------------------------------------------
  logic txTick;
  logic rxTick;

  // Divisors are not re-synchronised; changing them mid-frame corrupts it
  sbw_baud_div #(.CNT_W(DIV_W)) txDiv (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .prescaleSel(baud_reg[7:6]),
    .rateSel(baud_reg[5:3]),
    .fineFactor(txFine_reg),
    .run(txEn),
    .tick(txTick)
  );

  sbw_baud_div #(.CNT_W(DIV_W)) rxDiv (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .prescaleSel(baud_reg[7:6]),
    .rateSel(baud_reg[2:0]),
    .fineFactor(rxFine_reg),
    .run(rxEn),
    .tick(rxTick)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  sbw_tx_e txState_reg;
  logic [10:0] txShift_reg;
  logic [3:0] txLeft_reg;
  logic [3:0] txSub_reg;
  logic txPreamble_reg;
  logic txBitEnd;
  logic [3:0] txFrameLen;

  assign txBitEnd = txTick && (txSub_reg == OVERSAMPLE_LAST);
  assign txFrameLen = wordLen9 ? FRAME_9 : FRAME_8;
  assign txLoad = txBitEnd && (txState_reg == TX_IDLE) && txEn && !txPreamble_reg
                  && !ctrl2_reg[C2_BREAK] && !txEmpty_reg;
  assign txFinish = txBitEnd && (txState_reg == TX_SEND) && (txLeft_reg == 4'h1);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txSub_reg <= 4'h0;
    end else if (!txEn) begin
      txSub_reg <= 4'h0;
    end else if (txTick) begin
      txSub_reg <= txSub_reg + 4'h1;
    end
  end

  // An idle frame goes out each time the transmitter is enabled
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txPreamble_reg <= 1'b0;
    end else if (wrCtrl2 && regWrData[C2_TXEN] && !txEn) begin
      txPreamble_reg <= 1'b1;
    end else if (txBitEnd && (txState_reg == TX_IDLE)) begin
      txPreamble_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txState_reg <= TX_IDLE;
      txShift_reg <= 11'h7FF;
      txLeft_reg <= 4'h0;
    end else if (!txEn) begin
      txState_reg <= TX_IDLE;
      txShift_reg <= 11'h7FF;
    end else if (txBitEnd) begin
      unique case (txState_reg)
        TX_IDLE: begin
          txLeft_reg <= txFrameLen;
          if (txPreamble_reg) begin
            txShift_reg <= 11'h7FF;
            txState_reg <= TX_SEND;
          end else if (ctrl2_reg[C2_BREAK]) begin
            txShift_reg <= 11'h000;
            txState_reg <= TX_BREAK;
          end else if (!txEmpty_reg) begin
            // Start low, data lsb first, stop high
            txShift_reg <= wordLen9 ? {1'b1, ctrl1_reg[C1_TXBIT8], txHold_reg, 1'b0}
                                    : {2'b11, txHold_reg, 1'b0};
            txState_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          txShift_reg <= {1'b1, txShift_reg[10:1]};
          txLeft_reg <= txLeft_reg - 4'h1;
          if (txLeft_reg == 4'h1) begin
            txState_reg <= TX_IDLE;
          end
        end
        TX_BREAK: begin
          txLeft_reg <= txLeft_reg - 4'h1;
          if (txLeft_reg == 4'h1) begin
            if (ctrl2_reg[C2_BREAK]) begin
              txLeft_reg <= txFrameLen;
            end else begin
              // One mark bit so the next start edge is seen
              txShift_reg <= 11'h7FF;
              txLeft_reg <= 4'h1;
              txState_reg <= TX_MARK;
            end
          end
        end
        TX_MARK: txState_reg <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txdOut <= 1'b1;
    end else begin
      txdOut <= (txState_reg == TX_IDLE) ? 1'b1 : txShift_reg[0];
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  sbw_rx_e rxState_reg;
  logic rxSync1_reg;
  logic rxLine_reg;
  logic [3:0] rxSub_reg;
  logic [3:0] rxLeft_reg;
  logic [8:0] rxShift_reg;
  logic [7:0] idleCnt_reg;
  logic idleArmed_reg;
  logic [7:0] idleTicks;

  assign idleTicks = wordLen9 ? IDLE_TICKS_9 : IDLE_TICKS_8;
  // Byte position depends on word length since bits enter at the top
  assign rxWord = wordLen9 ? rxShift_reg[7:0] : rxShift_reg[8:1];
  assign rxWord8 = wordLen9 ? rxShift_reg[8] : 1'b0;
  assign rxDone = rxTick && (rxState_reg == RX_STOP) && (rxSub_reg == OVERSAMPLE_LAST);
  assign rxStopBad = !rxLine_reg;
  // Idle is a full frame time of ones after a reception
  assign idleSeen = rxTick && (rxState_reg == RX_IDLE) && idleArmed_reg && rxLine_reg
                    && (idleCnt_reg == idleTicks - 8'h01);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxSync1_reg <= 1'b1;
      rxLine_reg <= 1'b1;
    end else begin
      rxSync1_reg <= rxdIn;
      rxLine_reg <= rxSync1_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      idleCnt_reg <= 8'h00;
      idleArmed_reg <= 1'b0;
    end else if (!rxEn || rxDone) begin
      idleCnt_reg <= 8'h00;
      idleArmed_reg <= rxEn;
    end else if (rxTick && (rxState_reg == RX_IDLE)) begin
      if (!rxLine_reg) begin
        idleCnt_reg <= 8'h00;
      end else if (idleSeen) begin
        idleArmed_reg <= 1'b0;
      end else begin
        idleCnt_reg <= idleCnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxState_reg <= RX_IDLE;
      rxSub_reg <= 4'h0;
      rxLeft_reg <= 4'h0;
      rxShift_reg <= 9'h000;
    end else if (!rxEn) begin
      rxState_reg <= RX_IDLE;
      rxSub_reg <= 4'h0;
    end else if (rxTick) begin
      rxSub_reg <= rxSub_reg + 4'h1;
      unique case (rxState_reg)
        RX_IDLE: begin
          rxSub_reg <= 4'h0;
          if (!rxLine_reg) begin
            rxState_reg <= RX_START;
          end
        end
        RX_START: begin
          if (rxSub_reg == START_MID) begin
            rxSub_reg <= 4'h0;
            rxLeft_reg <= wordLen9 ? BITS_9 : BITS_8;
            rxState_reg <= rxLine_reg ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxSub_reg == OVERSAMPLE_LAST) begin
            rxShift_reg <= {rxLine_reg, rxShift_reg[8:1]};
            rxLeft_reg <= rxLeft_reg - 4'h1;
            if (rxLeft_reg == 4'h1) begin
              rxState_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // Break or lost sync shows as a low stop sample
          if (rxSub_reg == OVERSAMPLE_LAST) begin
            rxState_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

endmodule : sbw_serial

// ---- sbw_serial_chk.sv ----
`timescale 1ns/10ps
module sbw_serial_chk #(
  parameter int DIV_W = 19
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [sbw_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  // Serial lines
  input wire logic txdOut,
  input wire logic rxdIn,
  // Receive request level
  input wire logic rxIrqReq
);
  import sbw_pkg::*;
  logic [7:0] baudReg, txFineReg, rxFineReg, ctrl1Reg, ctrl2Reg, runCntReg;
  logic txEverReg, lastTxdReg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ----------
  // Shadows
  // ----------
  // Mute bit is left out: hardware clears it unseen
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      baudReg <= BAUD_RST;
      txFineReg <= FINE_RST;
      rxFineReg <= FINE_RST;
      ctrl1Reg <= CTRL_RST;
      ctrl2Reg <= CTRL_RST;
    end else if (regWrStb) begin
      case (regAddr)
        BAUD_OFS: baudReg <= regWrData;
        TXFINE_OFS: txFineReg <= regWrData;
        RXFINE_OFS: rxFineReg <= regWrData;
        CTRL1_OFS: ctrl1Reg <= regWrData;
        CTRL2_OFS: ctrl2Reg <= regWrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txEverReg <= 1'b0;
    end else if (regWrStb && regAddr == CTRL2_OFS && regWrData[C2_TXEN]) begin
      txEverReg <= 1'b1;
    end
  end

  // Length of the current level on the line, saturating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lastTxdReg <= 1'b1;
      runCntReg <= 8'h00;
    end else begin
      lastTxdReg <= txdOut;
      runCntReg <= (txdOut != lastTxdReg) ? 8'h00 : runCntReg + {7'h00, runCntReg != 8'hFF};
    end
  end

  // ----------
  // Properties
  // ----------
  rd_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  status_gaps_a: assert property ($past(regRdStb) && $past(regAddr) == STATUS_OFS
    |-> (regRdData & 8'h0D) == 8'h00) else $error("unused status bits not zero");
  unmapped_zero_a: assert property ($past(regRdStb) && $past(regAddr) == 3'h7
    |-> regRdData == 8'h00) else $error("unmapped index read not zero");
  baud_readback_a: assert property ($past(regRdStb) && $past(regAddr) == BAUD_OFS
    |-> regRdData == $past(baudReg)) else $error("baud register readback wrong");
  txfine_readback_a: assert property ($past(regRdStb) && $past(regAddr) == TXFINE_OFS
    |-> regRdData == $past(txFineReg)) else $error("tx fine readback wrong");
  rxfine_readback_a: assert property ($past(regRdStb) && $past(regAddr) == RXFINE_OFS
    |-> regRdData == $past(rxFineReg)) else $error("rx fine readback wrong");
  ctrl1_readback_a: assert property ($past(regRdStb) && $past(regAddr) == CTRL1_OFS
    |-> (regRdData & 8'h58) == ($past(ctrl1Reg) & 8'h58)) else $error("control one readback wrong");
  tx_quiet_a: assert property (!txEverReg |-> txdOut)
    else $error("line left high level before transmit enable");
  bit_width_a: assert property (txdOut != lastTxdReg |-> runCntReg >= 8'd15)
    else $error("line level shorter than sixteen clocks");
  irq_masked_a: assert property (!ctrl2Reg[C2_RXIE] && !ctrl2Reg[C2_IDLEIE]
    && !$past(ctrl2Reg[C2_RXIE]) && !$past(ctrl2Reg[C2_IDLEIE]) |-> !rxIrqReq)
    else $error("receive request with both enables off");
endmodule : sbw_serial_chk

bind sbw_serial sbw_serial_chk #(.DIV_W(DIV_W)) chk_u (.sys_clk(sys_clk), .nrst(nrst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .txdOut(txdOut), .rxdIn(rxdIn), .rxIrqReq(rxIrqReq));

// ---- sbw_peer.sv ----
`timescale 1ns/10ps
module sbw_peer (
  // Clock
  input wire logic sys_clk,
  // Serial lines
  input wire logic txdOut,
  output logic rxdIn,
  // Capture side
  input wire logic [15:0] bitCyc,
  output logic [9:0] capWord,
  output logic [15:0] capCnt
);
  // ----------
  // Sender
  // ----------
  initial rxdIn = 1'b1;

  task automatic send(input logic [8:0] w, input int nb, input logic stopV, input int cyc);
    logic b;
    for (int i = 0; i < nb + 3; i++) begin
      b = (i == 0) ? 1'b0 : (i <= nb) ? w[i-1] : (i == nb + 1) ? stopV : 1'b1;
      repeat (cyc) begin
        @(posedge sys_clk);
        rxdIn <= b;
      end
    end
  endtask : send

  // ----------
  // Receiver
  // ----------
  // Samples ten bit middles after the start bit; a break is waited out
  initial begin
    capWord = 10'h000;
    capCnt = 16'h0000;
    forever begin
      @(posedge sys_clk);
      if (txdOut === 1'b0) begin
        repeat (bitCyc / 2) @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
          repeat (bitCyc) @(posedge sys_clk);
          capWord[i] = txdOut;
        end
        capCnt = capCnt + 16'h0001;
        while (txdOut !== 1'b1) @(posedge sys_clk);
      end
    end
  end
endmodule : sbw_peer

// ---- sbw_serial_test.sv ----
`timescale 1ns/10ps
module sbw_serial_test;
  import sbw_pkg::*;
  logic sys_clk, nrst, regWrStb, regRdStb, txdOut, rxdIn, rxIrqReq;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [15:0] bitCyc, capCnt;
  logic [9:0] capWord;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  // Control one, baud, tx fine, clocks per bit
  localparam logic [31:0] TX_CASES [10] = '{32'h00000010, 32'h00400030, 32'h00800040,
    32'h00C000D0, 32'h00080020, 32'h00070010, 32'h00180080, 32'h00000330, 32'h000805A0,
    32'h50000010};

  sbw_serial dut_u (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .txdOut(txdOut),
    .rxdIn(rxdIn), .rxIrqReq(rxIrqReq));
  sbw_peer peer_u (.sys_clk(sys_clk), .txdOut(txdOut), .rxdIn(rxdIn), .bitCyc(bitCyc),
    .capWord(capWord), .capCnt(capCnt));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------
  // Helpers
  // ----------
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #10;
    chk({2'b00, regRdData & m}, {2'b00, e});
  endtask : rdchk

  task automatic flush(input logic [7:0] last);
    repeat (300) @(posedge sys_clk);
    rdchk(STATUS_OFS, 8'h30, 8'h10);
    rdchk(DATA_OFS, 8'hFF, last);
  endtask : flush

  // Rates are only changed with both directions off
  task automatic rx_rate(input logic [7:0] b, input logic [7:0] f, input int cyc,
                         input logic [7:0] w);
    wr(CTRL2_OFS, 8'h00);
    wr(BAUD_OFS, b);
    wr(RXFINE_OFS, f);
    wr(CTRL2_OFS, 8'h24);
    peer_u.send({1'b0, w}, 8, 1'b1, cyc);
    rdchk(STATUS_OFS, 8'h22, 8'h20);
    rdchk(DATA_OFS, 8'hFF, w);
  endtask : rx_rate

  task automatic tx_word(input logic [7:0] ctl, input logic [9:0] exp);
    logic [15:0] n;
    int k;
    n = capCnt;
    k = 0;
    wr(CTRL2_OFS, ctl);
    while (capCnt == n && k < 6000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 6000) num_errors++;
    chk(capWord, exp);
  endtask : tx_word

  // ----------
  // Scenarios
  // ----------
  task automatic test_regs;
    rdchk(STATUS_OFS, 8'hFF, 8'hC0);
    rdchk(BAUD_OFS, 8'hFF, BAUD_RST);
    rdchk(TXFINE_OFS, 8'hFF, FINE_RST);
    rdchk(RXFINE_OFS, 8'hFF, FINE_RST);
    wr(BAUD_OFS, 8'hE9);
    rdchk(BAUD_OFS, 8'hFF, 8'hE9);
    wr(3'h7, 8'hFF);
    rdchk(3'h7, 8'hFF, 8'h00);
    wr(BAUD_OFS, 8'h00);
    wr(DATA_OFS, 8'h77);
    rdchk(DATA_OFS, 8'hFF, 8'h00);
    rdchk(STATUS_OFS, 8'h80, 8'h00);
  endtask : test_regs

  task automatic test_rx;
    wr(CTRL2_OFS, 8'h24);
    peer_u.send(9'h0A5, 8, 1'b1, 16);
    rdchk(STATUS_OFS, 8'h22, 8'h20);
    chk({9'h000, rxIrqReq}, 10'h001);
    rdchk(DATA_OFS, 8'hFF, 8'hA5);
    peer_u.send(9'h03C, 8, 1'b0, 16);
    rdchk(DATA_OFS, 8'hFF, 8'h3C);
    rdchk(STATUS_OFS, 8'h22, 8'h22);
    rdchk(DATA_OFS, 8'hFF, 8'h3C);
    rdchk(STATUS_OFS, 8'h22, 8'h00);
    peer_u.send(9'h000, 8, 1'b0, 16);
    rdchk(STATUS_OFS, 8'h22, 8'h22);
    rdchk(DATA_OFS, 8'hFF, 8'h00);
    rdchk(STATUS_OFS, 8'h22, 8'h00);
    chk({9'h000, rxIrqReq}, 10'h000);
    wr(CTRL1_OFS, 8'h10);
    peer_u.send(9'h1C3, 9, 1'b1, 16);
    rdchk(CTRL1_OFS, 8'h80, 8'h80);
    rdchk(DATA_OFS, 8'hFF, 8'hC3);
    wr(CTRL1_OFS, 8'h00);
    rx_rate(8'h02, 8'h00, 64, 8'h69);
    rx_rate(8'hC1, 8'h00, 416, 8'hA3);
    rx_rate(8'h38, 8'h00, 16, 8'h5C);
    rx_rate(8'h00, 8'h03, 48, 8'h96);
    rx_rate(8'h00, 8'h00, 16, 8'h11);
  endtask : test_rx

  task automatic test_mute;
    flush(8'h11);
    wr(CTRL1_OFS, 8'h08);
    wr(CTRL2_OFS, 8'h26);
    peer_u.send(9'h012, 8, 1'b1, 16);
    repeat (300) @(posedge sys_clk);
    chk({9'h000, rxIrqReq}, 10'h000);
    rdchk(STATUS_OFS, 8'h32, 8'h00);
    rdchk(CTRL2_OFS, 8'h02, 8'h02);
    peer_u.send(9'h085, 8, 1'b1, 16);
    rdchk(CTRL2_OFS, 8'h02, 8'h00);
    rdchk(STATUS_OFS, 8'h20, 8'h20);
    rdchk(DATA_OFS, 8'hFF, 8'h85);
    flush(8'h85);
    wr(CTRL1_OFS, 8'h00);
    wr(CTRL2_OFS, 8'h26);
    peer_u.send(9'h012, 8, 1'b1, 16);
    rdchk(CTRL2_OFS, 8'h02, 8'h02);
    repeat (300) @(posedge sys_clk);
    rdchk(CTRL2_OFS, 8'h02, 8'h00);
    rdchk(STATUS_OFS, 8'h30, 8'h00);
  endtask : test_mute

  task automatic test_tx;
    logic [31:0] c;
    logic [7:0] d;
    for (int i = 0; i < 10; i++) begin
      c = TX_CASES[i];
      d = 8'h5A ^ 8'(i * 37);
      wr(CTRL2_OFS, 8'h00);
      wr(CTRL1_OFS, c[31:24]);
      wr(BAUD_OFS, c[23:16]);
      wr(TXFINE_OFS, c[15:8]);
      bitCyc = {8'h00, c[7:0]};
      wr(DATA_OFS, d);
      tx_word(8'h08, {1'b1, c[28] ? c[30] : 1'b1, d});
    end
    wr(CTRL2_OFS, 8'h00);
    wr(CTRL1_OFS, 8'h00);
    tx_word(8'h09, 10'h000);
    wr(DATA_OFS, 8'hC3);
    tx_word(8'h08, {2'b11, 8'hC3});
  endtask : test_tx

  task automatic wrap_up;
    $display("compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    nrst = 1'b0;
    regAddr = '0;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    bitCyc = 16'h0010;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    test_regs();
    test_rx();
    test_mute();
    test_tx();
    wrap_up();
  end
endmodule : sbw_serial_test
